// ==== rtl/pimoc_bank.sv ====
/*
 * Per-port interrupt enable, interrupt status and operation control
 * registers for ports 1 to 7, with an APB slave, the interrupt output,
 * MAC loopback steering and egress queue selection.
 * Assumes: one core clock; event pulses, fabric beats and line beats come
 * from logic on core_clk; software keeps tail tagging to one port.
 */
// Decided for this implementation: the APB slave port.
// How it works
// - seven ports, three registers each
// - enable bit zero forwards source; reset enables
// - bit 3 negotiation-done source, port 7 only
// - bit 2 precision-time source, PHY ports only
// - bit 0 access-list everywhere; bit 1 PHY ports
// - bit 7 returns fabric egress to fabric
// - bit 6 returns line receive to line
// - far loop uses line receive, line transmit
// - bit 2 enables tail tagging, resets clear
// - bits 1:0 choose one, two, four queues
// - split modes queue frames by priority
// - status bits share enable bit positions
// - toggling access-list enable clears its status
`timescale 1ns/10ps
`default_nettype none

module pimoc_bank #(
   parameter logic [6:0] PHY_PORTS = pimoc_pkg::PHY_PORTS_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB slave
   input wire pimoc_pkg::pimoc_apb_req_type apb_req,
   output pimoc_pkg::pimoc_apb_rsp_type apb_rsp,
   // Interrupt
   output logic irq,
   // Event pulses per port, bit order sgmii, ptp, phy, acl
   input wire logic [7:1][3:0] port_event,
   // Frame beats
   input wire pimoc_pkg::pimoc_beat_type [7:1] fab_tx,
   input wire pimoc_pkg::pimoc_beat_type [7:1] line_rx,
   output pimoc_pkg::pimoc_beat_type [7:1] fab_rx,
   output pimoc_pkg::pimoc_beat_type [7:1] line_tx,
   // Egress queueing and tagging
   input wire logic [7:1][2:0] egr_prio,
   output logic [7:1][1:0] egr_queue,
   output logic [7:1] tail_tag_en
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      pimoc_pkg::pimoc_apb_state_type apb_st; // Slave phase
      pimoc_pkg::pimoc_apb_rsp_type rsp;      // Registered answer
      logic [7:1][3:0] inten;                 // Active-low enables
      logic [7:1][3:0] status;                // Sticky event flags
      logic [7:1][7:0] opctl;                 // Operation control
      logic irq;                              // Interrupt level
   } pimoc_bank_state_type;

   pimoc_bank_state_type st;      // Registered copy
   pimoc_bank_state_type next_st; // Computed copy

   // Decoded register access
   typedef struct packed {
      pimoc_pkg::pimoc_sel_type sel;
      logic [2:0] port;
   } pimoc_dec_type;

   // ----------------------------------------------------------------
   // Address decode: index in paddr[13:2], port in the top nibble
   // ----------------------------------------------------------------
   function automatic pimoc_dec_type decode(input logic [pimoc_pkg::ADDR_W-1:0] a);
      logic [3:0] pn;
      logic [11:0] off;
      pn = a[17:14];
      off = a[13:2];
      decode.port = pn[2:0];
      decode.sel = pimoc_pkg::PIMOC_SEL_NONE;
      // Ports 1..7 only; misaligned bytes are unmapped
      if (pn >= 4'h1 && pn <= 4'h7 && a[1:0] == 2'b00) begin
         if (off == pimoc_pkg::IDX_INT_STATUS) begin
            decode.sel = pimoc_pkg::PIMOC_SEL_STATUS;
         end else if (off == pimoc_pkg::IDX_INT_ENABLE) begin
            decode.sel = pimoc_pkg::PIMOC_SEL_ENABLE;
         end else if (off == pimoc_pkg::IDX_OP_CTRL) begin
            decode.sel = pimoc_pkg::PIMOC_SEL_OPCTL;
         end
      end
   endfunction

   // Which status bits a port can ever raise
   function automatic logic [3:0] applicable(input int p);
      applicable = '0;
      applicable[pimoc_pkg::BIT_ACL] = 1'b1;
      applicable[pimoc_pkg::BIT_PHY] = PHY_PORTS[p-1];
      applicable[pimoc_pkg::BIT_PTP] = PHY_PORTS[p-1];
      applicable[pimoc_pkg::BIT_SGMII] = (4'(p) == pimoc_pkg::SGMII_PORT);
   endfunction

   pimoc_dec_type dec;  // Decode of the current address
   logic wr_fire;       // Write completes at this edge
   logic [3:0] wdat4;   // Low nibble of write data
   logic [7:0] wdat8;   // Low byte of write data

   assign dec = decode(apb_req.paddr);
   assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb[0]
      && st.apb_st == pimoc_pkg::PIMOC_APB_ANSWER;
   assign wdat4 = apb_req.pwdata[3:0];
   assign wdat8 = apb_req.pwdata[7:0];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [3:0] clr;
      logic [3:0] newen;
      next_st = st;
      clr = '0;
      newen = '0;
      next_st.rsp.pready = 1'b0;
      // Bus phases: answer one cycle after the setup cycle
      case (st.apb_st)
         pimoc_pkg::PIMOC_APB_IDLE: begin
            if (apb_req.psel && !apb_req.penable) begin
               next_st.apb_st = pimoc_pkg::PIMOC_APB_ANSWER;
               next_st.rsp.pready = 1'b1;
               next_st.rsp.pslverr = (dec.sel == pimoc_pkg::PIMOC_SEL_NONE);
               next_st.rsp.prdata = '0;
               // Read data captured at setup; upper bits stay zero
               case (dec.sel)
                  pimoc_pkg::PIMOC_SEL_STATUS: next_st.rsp.prdata[3:0] = st.status[dec.port];
                  pimoc_pkg::PIMOC_SEL_ENABLE: next_st.rsp.prdata[3:0] = st.inten[dec.port];
                  pimoc_pkg::PIMOC_SEL_OPCTL: next_st.rsp.prdata[7:0] = st.opctl[dec.port];
                  default: next_st.rsp.prdata = '0;
               endcase
            end
         end
         pimoc_pkg::PIMOC_APB_ANSWER: begin
            next_st.apb_st = pimoc_pkg::PIMOC_APB_IDLE;
            next_st.rsp.pslverr = 1'b0;
         end
         default: next_st.apb_st = pimoc_pkg::PIMOC_APB_IDLE;
      endcase
      // Register writes take effect on the completing edge
      for (int p = 1; p <= 7; p++) begin
         clr = '0;
         if (wr_fire && 3'(p) == dec.port) begin
            case (dec.sel)
               pimoc_pkg::PIMOC_SEL_STATUS: begin
                  clr = wdat4; // Write one to clear
               end
               pimoc_pkg::PIMOC_SEL_ENABLE: begin
                  newen = wdat4;
                  // A change of the access-list enable clears its flag
                  if (newen[pimoc_pkg::BIT_ACL] != st.inten[p][pimoc_pkg::BIT_ACL]) begin
                     clr[pimoc_pkg::BIT_ACL] = 1'b1;
                  end
                  next_st.inten[p] = newen;
               end
               pimoc_pkg::PIMOC_SEL_OPCTL: begin
                  next_st.opctl[p] = wdat8 & pimoc_pkg::OP_CTRL_WMASK;
               end
               default: clr = '0;
            endcase
         end
         // Events win over a clear in the same cycle
         next_st.status[p] = (st.status[p] & ~clr) | (port_event[p] & applicable(p));
      end
      // Level interrupt from flags whose enable bit is zero
      next_st.irq = 1'b0;
      for (int p = 1; p <= 7; p++) begin
         next_st.irq = next_st.irq | (|(next_st.status[p] & ~next_st.inten[p]));
      end
   end

   // ----------------------------------------------------------------
   // Register the state
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st.apb_st <= pimoc_pkg::PIMOC_APB_IDLE;
         st.rsp <= '0;
         st.inten <= {7{pimoc_pkg::INT_ENABLE_RST}};
         st.status <= {7{pimoc_pkg::INT_STATUS_RST}};
         st.opctl <= {7{pimoc_pkg::OP_CTRL_RST}};
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Control fan-out to the datapath helpers
   // ----------------------------------------------------------------
   logic [7:1] local_loop;      // Fabric-side loop per port
   logic [7:1] remote_loop;     // Line-side loop per port
   logic [7:1][1:0] split_mode; // Queue split per port

   always_comb begin
      for (int p = 1; p <= 7; p++) begin
         local_loop[p] = st.opctl[p][pimoc_pkg::OP_LOCAL_LOOP];
         remote_loop[p] = st.opctl[p][pimoc_pkg::OP_REMOTE_LOOP];
         split_mode[p] = st.opctl[p][pimoc_pkg::OP_SPLIT_LSB +: 2];
         tail_tag_en[p] = st.opctl[p][pimoc_pkg::OP_TAIL_TAG];
      end
   end

   // Loopback steering; the far loop has no elastic buffer, short frames only
   pimoc_loop #(
      .NPORT(7)
   ) u_loop (
      .core_clk(core_clk),
      .nrst(nrst),
      .local_loop(local_loop),
      .remote_loop(remote_loop),
      .fab_tx(fab_tx),
      .line_rx(line_rx),
      .fab_rx(fab_rx),
      .line_tx(line_tx)
   );

   // Queue choice from priority
   pimoc_qmap #(
      .NPORT(7)
   ) u_qmap (
      .core_clk(core_clk),
      .nrst(nrst),
      .split(split_mode),
      .prio(egr_prio),
      .queue(egr_queue)
   );

   assign apb_rsp = st.rsp;
   assign irq = st.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking ast_clk @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Helpers: flags that a port must never hold
   logic [7:1] bad_sgmii; // Negotiation flag off port 7
   logic [7:1] bad_phy;   // PHY or time flag on a MAC port
   always_comb begin
      for (int p = 1; p <= 7; p++) begin
         bad_sgmii[p] = (p != 7) && st.status[p][pimoc_pkg::BIT_SGMII];
         bad_phy[p] = !PHY_PORTS[p-1] && (|st.status[p][2:1]);
      end
   end

   AST_APB_ANSWER: assert property (
      apb_req.psel && !apb_req.penable && st.apb_st == pimoc_pkg::PIMOC_APB_IDLE
      |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("Slave did not answer one cycle after setup");

   AST_ACL_RAISES_IRQ: assert property (
      port_event[6][pimoc_pkg::BIT_ACL] && !st.inten[6][pimoc_pkg::BIT_ACL] && !wr_fire
      |=> irq && st.status[6][pimoc_pkg::BIT_ACL])
      else $error("Enabled access-list event did not raise the interrupt");

   AST_MASKED_QUIET: assert property (
      (&st.inten[1] && &st.inten[2] && &st.inten[3] && &st.inten[4] && &st.inten[5]
       && &st.inten[6] && &st.inten[7]) && $stable(st.inten) |-> !$rose(irq))
      else $error("Interrupt rose while every source was blocked");

   AST_SGMII_PORT7: assert property (bad_sgmii == '0)
      else $error("Negotiation flag set on a port other than 7");

   AST_PHY_ONLY: assert property (bad_phy == '0)
      else $error("PHY or time flag set on a port without a PHY");

   AST_ACL_TOGGLE: assert property (
      wr_fire && dec.sel == pimoc_pkg::PIMOC_SEL_ENABLE && dec.port == 3'd6
      && wdat4[0] != st.inten[6][0] && !port_event[6][0]
      |=> !st.status[6][pimoc_pkg::BIT_ACL])
      else $error("Toggling the access-list enable left its flag set");

   AST_RSVD_ZERO: assert property (
      apb_rsp.pready && $past(dec.sel) == pimoc_pkg::PIMOC_SEL_ENABLE
      |-> apb_rsp.prdata[31:4] == '0)
      else $error("Reserved enable bits read nonzero");

   AST_TAIL_TAG: assert property (
      wr_fire && dec.sel == pimoc_pkg::PIMOC_SEL_OPCTL && dec.port == 3'd4
      |=> tail_tag_en[4] == $past(apb_req.pwdata[2]))
      else $error("Tail tag output does not follow the written bit");

   AST_LOCAL_LOOP: assert property (
      local_loop[3] |=> fab_rx[3] == $past(fab_tx[3]))
      else $error("Local loopback did not return fabric data");

   AST_REMOTE_LOOP: assert property (
      remote_loop[1] |=> line_tx[1] == $past(line_rx[1])
      ##0 (local_loop[1] || $past(local_loop[1]) || !fab_rx[1].valid))
      else $error("Remote loopback leaked or lost line data");

   AST_ONE_QUEUE: assert property (
      split_mode[6] == 2'b00 |=> egr_queue[6] == 2'b00)
      else $error("Single queue mode chose a nonzero queue");

   AST_FOUR_QUEUE: assert property (
      split_mode[4] == 2'b10 |=> egr_queue[4] == $past(egr_prio[4][2:1]))
      else $error("Four queue mode ignored priority");

   COV_IRQ_SET: cover property (!irq ##1 irq);
   COV_STATUS_W1C: cover property (wr_fire && dec.sel == pimoc_pkg::PIMOC_SEL_STATUS);
   COV_BOTH_LOOPS: cover property (local_loop[1] && remote_loop[1]);
   COV_SLVERR: cover property (apb_rsp.pready && apb_rsp.pslverr);

endmodule // pimoc_bank

`default_nettype wire

// ==== rtl/pimoc_loop.sv ====
/*
 * Per-port MAC loopback steering for all ports, registered.
 * Assumes: fabric and line beats are on core_clk; the line side stands
 * for the PHY pair or the media-independent data pins alike.
 */
`timescale 1ns/10ps
`default_nettype none

module pimoc_loop #(
   parameter int NPORT = 7
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Loopback controls
   input wire logic [NPORT:1] local_loop,
   input wire logic [NPORT:1] remote_loop,
   // Inbound beats
   input wire pimoc_pkg::pimoc_beat_type [NPORT:1] fab_tx,
   input wire pimoc_pkg::pimoc_beat_type [NPORT:1] line_rx,
   // Outbound beats
   output pimoc_pkg::pimoc_beat_type [NPORT:1] fab_rx,
   output pimoc_pkg::pimoc_beat_type [NPORT:1] line_tx
);

   typedef struct packed {
      pimoc_pkg::pimoc_beat_type [NPORT:1] fab_rx;
      pimoc_pkg::pimoc_beat_type [NPORT:1] line_tx;
   } pimoc_loop_state_type;

   pimoc_loop_state_type st;      // Registered copy
   pimoc_loop_state_type next_st; // Computed copy

   // ----------------------------------------------------------------
   // Steering; both loops may run at once since they use separate paths
   // ----------------------------------------------------------------
   always_comb begin
      next_st = '0;
      for (int p = 1; p <= NPORT; p++) begin
         // Fabric egress turned round, never reaching the line
         if (local_loop[p]) begin
            next_st.fab_rx[p] = fab_tx[p];
         end else if (!remote_loop[p]) begin
            next_st.fab_rx[p] = line_rx[p];
         end
         // Line receive turned round onto line transmit; no elastic buffer here
         if (remote_loop[p]) begin
            next_st.line_tx[p] = line_rx[p];
         end else if (!local_loop[p]) begin
            next_st.line_tx[p] = fab_tx[p];
         end
      end
   end

   // Register the copy
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fab_rx = st.fab_rx;
   assign line_tx = st.line_tx;

endmodule // pimoc_loop

`default_nettype wire

// ==== rtl/pimoc_pkg.sv ====
/*
 * Shared constants and carrier types for the per-port interrupt enable and
 * operation control register bank (ports 1 to 7).
 * Assumes: a single core clock, an APB slave with 32-bit data, and that
 * every consumer refers to these names as pimoc_pkg::name.
 */
package pimoc_pkg;

   // ----------------------------------------------------------------
   // Port range and geometry
   // ----------------------------------------------------------------
   localparam int NPORT = 7;                       // Ports 1..7
   localparam logic [3:0] SGMII_PORT = 4'h7;        // Only port with serial negotiation
   localparam logic [6:0] PHY_PORTS_DEF = 7'h1F;    // Ports 1..5 carry an integrated PHY
   localparam int ADDR_W = 18;                     // Byte address: index times four

   // ----------------------------------------------------------------
   // Register indexes (low 12 bits; the port number is the nibble above)
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_INT_STATUS = 12'h01B; // Sticky event flags
   localparam logic [11:0] IDX_INT_ENABLE = 12'h01F; // Active-low enables
   localparam logic [11:0] IDX_OP_CTRL = 12'h020;    // Loopback, tail tag, split

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_ACL = 0;          // Access-list event
   localparam int BIT_PHY = 1;          // PHY event
   localparam int BIT_PTP = 2;          // Aggregated precision-time event
   localparam int BIT_SGMII = 3;        // Serial negotiation done
   localparam int OP_LOCAL_LOOP = 7;    // Fabric-side loopback
   localparam int OP_REMOTE_LOOP = 6;   // Line-side loopback
   localparam int OP_TAIL_TAG = 2;      // Host port tagging
   localparam int OP_SPLIT_LSB = 0;     // Queue split field, two bits

   // ----------------------------------------------------------------
   // Reset values and write masks
   // ----------------------------------------------------------------
   localparam logic [3:0] INT_ENABLE_RST = 4'h0;  // Every source enabled
   localparam logic [3:0] INT_STATUS_RST = 4'h0;
   localparam logic [7:0] OP_CTRL_RST = 8'h00;
   localparam logic [7:0] OP_CTRL_WMASK = 8'hC7;  // Bits 5:3 stay zero

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIMOC_SPLIT_ONE = 2'b00,
      PIMOC_SPLIT_TWO = 2'b01,
      PIMOC_SPLIT_FOUR = 2'b10,
      PIMOC_SPLIT_RSVD = 2'b11
   } pimoc_split_type;

   typedef enum logic [0:0] {
      PIMOC_APB_IDLE = 1'b0,
      PIMOC_APB_ANSWER = 1'b1
   } pimoc_apb_state_type;

   typedef enum logic [1:0] {
      PIMOC_SEL_NONE = 2'b00,
      PIMOC_SEL_STATUS = 2'b01,
      PIMOC_SEL_ENABLE = 2'b10,
      PIMOC_SEL_OPCTL = 2'b11
   } pimoc_sel_type;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } pimoc_beat_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } pimoc_apb_req_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pimoc_apb_rsp_type;

endpackage

// ==== rtl/pimoc_qmap.sv ====
/*
 * Egress queue selection from frame priority and the per-port split mode.
 * Assumes: priority is the 3-bit user priority of the frame, on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module pimoc_qmap #(
   parameter int NPORT = 7
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Split setting and frame priority
   input wire logic [NPORT:1][1:0] split,
   input wire logic [NPORT:1][2:0] prio,
   // Chosen queue
   output logic [NPORT:1][1:0] queue
);

   // Map one priority onto a queue; reserved split acts as a single queue
   function automatic logic [1:0] pick_queue(input logic [1:0] mode, input logic [2:0] pr);
      case (pimoc_pkg::pimoc_split_type'(mode))
         pimoc_pkg::PIMOC_SPLIT_TWO: pick_queue = {1'b0, pr[2]};
         pimoc_pkg::PIMOC_SPLIT_FOUR: pick_queue = pr[2:1];
         default: pick_queue = 2'b00;
      endcase
   endfunction

   typedef struct packed {
      logic [NPORT:1][1:0] queue;
   } pimoc_qmap_state_type;

   pimoc_qmap_state_type st;
   pimoc_qmap_state_type next_st;

   // ----------------------------------------------------------------
   // Queue choice per port
   // ----------------------------------------------------------------
   always_comb begin
      next_st = '0;
      for (int p = 1; p <= NPORT; p++) begin
         next_st.queue[p] = pick_queue(split[p], prio[p]);
      end
   end

   // Register the copy
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign queue = st.queue;

endmodule // pimoc_qmap

`default_nettype wire

// ==== tb/tb_pimoc_bank.sv ====
/*
 * Self-checking testbench for the per-port enable and operation control bank.
 * Assumes: pimoc_pkg compiled first; the bank answers APB in one access cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_pimoc_bank;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic core_clk = 1'b0; // 20 MHz core clock
   logic nrst = 1'b0; // Held low at start
   pimoc_pkg::pimoc_apb_req_type apb_req = '0;
   pimoc_pkg::pimoc_apb_rsp_type apb_rsp;
   logic irq;
   logic [7:1][3:0] port_event = '0; // Event pulses
   pimoc_pkg::pimoc_beat_type [7:1] fab_tx = '0;
   pimoc_pkg::pimoc_beat_type [7:1] line_rx = '0;
   pimoc_pkg::pimoc_beat_type [7:1] fab_rx;
   pimoc_pkg::pimoc_beat_type [7:1] line_tx;
   logic [7:1][2:0] egr_prio = '0;
   logic [7:1][1:0] egr_queue;
   logic [7:1] tail_tag_en;
   int failures = 0; // Mismatches
   int tests_run = 0; // Comparisons
   logic [31:0] rdata; // Last read data
   logic rerr; // Last slave error

   pimoc_bank i_pimoc_bank (
      .core_clk(core_clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .irq(irq), .port_event(port_event), .fab_tx(fab_tx), .line_rx(line_rx),
      .fab_rx(fab_rx), .line_tx(line_tx), .egr_prio(egr_prio),
      .egr_queue(egr_queue), .tail_tag_en(tail_tag_en)
   );

   // Free-running clock, 50 ns period
   always #25 core_clk = ~core_clk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("Counts: %0d compared, %0d mismatched", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // One comparison, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [3:0] p, input logic [11:0] idx,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= {p, idx, 2'b00};
      apb_req.pwdata <= {24'h00_0000, d};
      apb_req.pstrb <= 4'hf;
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      chk(32'(apb_rsp.pready), 32'h0000_0001);
      rdata = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Read and compare data and error flag
   task automatic rd(input logic [3:0] p, input logic [11:0] idx, input logic [7:0] e,
                     input logic ee);
      apb(1'b0, p, idx, 8'h00);
      chk(rdata, {24'h00_0000, e});
      chk(32'(rerr), 32'(ee));
   endtask

   // One-cycle event pulse, then let the flag land
   task automatic ev(input int p, input int b);
      @(posedge core_clk);
      port_event[p][b] <= 1'b1;
      @(posedge core_clk);
      port_event[p][b] <= 1'b0;
      @(negedge core_clk);
   endtask

   // ------------------------------------------------------------
   // Watchdog: the run needs a few hundred cycles at most
   // ------------------------------------------------------------
   initial begin
      #(50 * 20000);
      failures++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [1:0] m;
      logic [8:0] ef;
      logic [8:0] el;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      // Reset values on every port
      for (int p = 1; p <= 7; p++) begin
         rd(4'(p), pimoc_pkg::IDX_INT_ENABLE, 8'h00, 1'b0);
         rd(4'(p), pimoc_pkg::IDX_OP_CTRL, 8'h00, 1'b0);
         rd(4'(p), pimoc_pkg::IDX_INT_STATUS, 8'h00, 1'b0);
      end
      rd(4'h0, pimoc_pkg::IDX_OP_CTRL, 8'h00, 1'b1);
      rd(4'h8, pimoc_pkg::IDX_INT_ENABLE, 8'h00, 1'b1);
      $display("Test reset values done");
      // Reserved bits and tail tag
      apb(1'b1, 4'h3, pimoc_pkg::IDX_OP_CTRL, 8'hff);
      rd(4'h3, pimoc_pkg::IDX_OP_CTRL, 8'hc7, 1'b0);
      chk(32'(tail_tag_en), 32'h0000_0004);
      apb(1'b1, 4'h3, pimoc_pkg::IDX_INT_ENABLE, 8'hff);
      rd(4'h3, pimoc_pkg::IDX_INT_ENABLE, 8'h0f, 1'b0);
      apb(1'b1, 4'h3, pimoc_pkg::IDX_OP_CTRL, 8'h00);
      apb(1'b1, 4'h3, pimoc_pkg::IDX_INT_ENABLE, 8'h00);
      chk(32'(tail_tag_en), 32'h0000_0000);
      $display("Test reserved bits done");
      // Interrupt sources and enables
      ev(7, 3);
      rd(4'h7, pimoc_pkg::IDX_INT_STATUS, 8'h08, 1'b0);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b1, 4'h7, pimoc_pkg::IDX_INT_ENABLE, 8'h08);
      @(negedge core_clk);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, 4'h7, pimoc_pkg::IDX_INT_STATUS, 8'h08);
      apb(1'b1, 4'h7, pimoc_pkg::IDX_INT_ENABLE, 8'h00);
      ev(6, 1);
      ev(6, 2);
      ev(6, 3);
      rd(4'h6, pimoc_pkg::IDX_INT_STATUS, 8'h00, 1'b0);
      ev(2, 2);
      rd(4'h2, pimoc_pkg::IDX_INT_STATUS, 8'h04, 1'b0);
      ev(2, 1);
      rd(4'h2, pimoc_pkg::IDX_INT_STATUS, 8'h06, 1'b0);
      apb(1'b1, 4'h2, pimoc_pkg::IDX_INT_STATUS, 8'h06);
      ev(6, 0);
      rd(4'h6, pimoc_pkg::IDX_INT_STATUS, 8'h01, 1'b0);
      apb(1'b1, 4'h6, pimoc_pkg::IDX_INT_ENABLE, 8'h01);
      apb(1'b1, 4'h6, pimoc_pkg::IDX_INT_ENABLE, 8'h00);
      rd(4'h6, pimoc_pkg::IDX_INT_STATUS, 8'h00, 1'b0);
      chk(32'(irq), 32'h0000_0000);
      $display("Test interrupts done");
      // Loopback modes on port 1, all four combinations
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         apb(1'b1, 4'h1, pimoc_pkg::IDX_OP_CTRL, {m, 6'h00});
         ef = m[1] ? 9'h1a5 : (m[0] ? 9'h000 : 9'h13c);
         el = m[0] ? 9'h13c : (m[1] ? 9'h000 : 9'h1a5);
         @(posedge core_clk);
         fab_tx[1] <= 9'h1a5;
         line_rx[1] <= 9'h13c;
         @(posedge core_clk);
         fab_tx[1] <= '0;
         line_rx[1] <= '0;
         @(negedge core_clk);
         chk(32'(fab_rx[1]), 32'(ef));
         chk(32'(line_tx[1]), 32'(el));
      end
      $display("Test loopback done");
      // Queue split per mode and priority on port 4
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         apb(1'b1, 4'h4, pimoc_pkg::IDX_OP_CTRL, {6'h00, m});
         for (int pr = 0; pr < 8; pr++) begin
            @(posedge core_clk);
            egr_prio[4] <= 3'(pr);
            @(posedge core_clk);
            @(negedge core_clk);
            chk(32'(egr_queue[4]), (m == 2'b01) ? 32'(pr / 4) :
                (m == 2'b10) ? 32'(pr / 2) : 32'h0000_0000);
         end
      end
      $display("Test queue split done");
      complete_run();
   end
endmodule // tb_pimoc_bank

`default_nettype wire
